// [design/twr_chan.sv]
`timescale 1ns/100ps
module twr_chan
    import twr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    twr_chan_if.chan ch
);
    typedef struct packed {
        twr_waddr_type wp;
        logic          stalled;
        logic          en_prev;
    } twr_chan_state_type;

    twr_chan_state_type q;
    twr_chan_state_type d;
    twr_waddr_type      nxt;

    // =========================================================
    // pointer advance, wrap, stall and early warning
    always_comb begin
        d        = q;
        d.en_prev = ch.en;
        nxt      = (q.wp >= ch.stop) ? ch.start : twr_waddr_type'(q.wp + 1'b1);
        ch.warn_ev  = 1'b0;
        ch.stall_ev = 1'b0;
        if (ch.en && !q.en_prev) begin
            // reactivation restarts at the buffer start and lifts a stall
            d.wp      = ch.start;
            d.stalled = 1'b0;
        end else if (ch.wr && ch.en && !q.stalled) begin
            d.wp = nxt;
            if (nxt == ch.rp) begin
                d.stalled   = 1'b1;
                ch.stall_ev = 1'b1;
            end
            if (nxt == twr_waddr_type'(ch.rp - ch.sub)) begin
                ch.warn_ev = 1'b1;
            end
        end
    end

    assign ch.wp      = q.wp;
    assign ch.stalled = q.stalled;

    // =========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // =========================================================
    // checks
    stall_holds_ptr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && q.stalled && !(ch.en && !q.en_prev)) |=> $stable(q.wp))
        else $error("write pointer moved while stalled");
    wrap_to_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && ch.wr && ch.en && q.en_prev && !q.stalled && q.wp >= ch.stop)
        |=> q.wp == $past(ch.start))
        else $error("pointer did not wrap to start");
    reach_sets_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && ch.stall_ev && !(ch.en && !q.en_prev)) |=> q.stalled && q.wp == $past(ch.rp))
        else $error("stall not taken at read pointer");
endmodule

// [design/twr_chan_if.sv]
`timescale 1ns/100ps
interface twr_chan_if;
    import twr_pkg::*;
    logic          en;
    logic          wr;
    twr_waddr_type start;
    twr_waddr_type stop;
    twr_waddr_type rp;
    twr_waddr_type sub;
    twr_waddr_type wp;
    logic          stalled;
    logic          warn_ev;
    logic          stall_ev;
    modport cfg  (output en, wr, start, stop, rp, sub, input wp, stalled, warn_ev, stall_ev);
    modport chan (input en, wr, start, stop, rp, sub, output wp, stalled, warn_ev, stall_ev);
endinterface

// [design/twr_pkg.sv]
package twr_pkg;
    // =========================================================
    // channel layout
    localparam int NUM_CH       = 8;
    localparam int UNMATCHED_CH = 7;
    localparam int EN_STRIDE    = 4;
    localparam int ALIGN_BITS   = 3;
    localparam int WADDR_W      = 29;
    localparam int STS_STALL    = 8;
    localparam int MODE_BYPASS  = 0;
    localparam int CLK_PERIOD_NS = 8;
    // =========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFF_ENABLES  = 12'h000;
    localparam logic [11:0] OFF_MODE     = 12'h004;
    localparam logic [11:0] OFF_INT_STS  = 12'h008;
    localparam logic [11:0] OFF_INT_MASK = 12'h00C;
    localparam logic [11:0] OFF_START    = 12'h040;
    localparam logic [11:0] OFF_END      = 12'h060;
    localparam logic [11:0] OFF_RDPTR    = 12'h080;
    localparam logic [11:0] OFF_SUB      = 12'h0A0;
    localparam logic [11:0] OFF_WRPTR    = 12'h0C0;
    // =========================================================
    // reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [28:0] RST_WADDR = 29'h0000_0000;
    typedef logic [WADDR_W-1:0] twr_waddr_type;
endpackage

// [design/twr_route.sv]
`timescale 1ns/100ps
module twr_route
    import twr_pkg::*;
(
    input  wire logic       hit,
    input  wire logic [2:0] slot,
    input  wire logic [6:0] filter_en,
    input  wire logic [7:0] eff_en,
    input  wire logic       bypass,
    output logic      [2:0] chan,
    output logic            ok
);
    // =========================================================
    // channel choice for a packet head
    always_comb begin
        if (bypass) begin
            chan = 3'(UNMATCHED_CH);
        end else if (hit && slot != 3'(UNMATCHED_CH) && filter_en[slot]) begin
            chan = slot;
        end else begin
            chan = 3'(UNMATCHED_CH);
        end
        ok = eff_en[chan];
    end
endmodule

// [design/twr_top.sv]
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module twr_top
    import twr_pkg::*;
#(
    parameter int DATA_W = 64
)(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              PKT_VALID,
    input  wire logic              PKT_SOP,
    input  wire logic [DATA_W-1:0] PKT_DATA,
    input  wire logic              PKT_MATCH_HIT,
    input  wire logic [2:0]        PKT_MATCH_SLOT,
    input  wire logic [6:0]        PID_SLOT_FILTER_ENABLE,
    output logic                   PKT_READY,
    output logic                   MEM_WR_VALID,
    output logic [31:0]            MEM_WR_ADDR,
    output logic [DATA_W-1:0]      MEM_WR_DATA,
    input  wire logic              MEM_WR_READY,
    output logic                   IRQ
);
    // =========================================================
    // elaboration check: one memory word is eight bytes
    if (DATA_W != 64) begin : g_bad_width
        $error("DATA_W must be 64");
    end

    typedef struct packed {
        logic [7:0]                      en;
        logic                            bypass;
        logic [15:0]                     sts;
        logic [15:0]                     mask;
        logic [NUM_CH-1:0][WADDR_W-1:0]  start;
        logic [NUM_CH-1:0][WADDR_W-1:0]  stop;
        logic [NUM_CH-1:0][WADDR_W-1:0]  rp;
        logic [NUM_CH-1:0][WADDR_W-1:0]  sub;
        logic [2:0]                      pkt_ch;
        logic                            pkt_ok;
        logic                            pkt_ready;
        logic                            mem_valid;
        twr_waddr_type                   mem_addr;
        logic [DATA_W-1:0]               mem_data;
        logic                            pready;
        logic                            slverr;
        logic [31:0]                     prdata;
        logic                            irq;
    } twr_state_type;

    twr_state_type q;
    twr_state_type d;

    twr_chan_if ch_if [NUM_CH] ();

    logic [7:0]                     eff_en;
    logic [7:0]                     stalled;
    logic [7:0]                     warn_ev;
    logic [7:0]                     stall_ev;
    logic [NUM_CH-1:0][WADDR_W-1:0] wp;
    logic [2:0]                     head_ch;
    logic                           head_ok;
    logic [2:0]                     cur_ch;
    logic                           cur_ok;
    logic                           accept;
    logic                           do_write;
    logic                           apb_done;

    // =========================================================
    // functions
    function automatic logic bank_hit(input logic [11:0] a, input logic [11:0] base);
        bank_hit = (a[11:5] == base[11:5]);
    endfunction

    function automatic logic [31:0] enables_word(input logic [7:0] e);
        logic [31:0] w;
        w = RST_WORD;
        for (int i = 0; i < NUM_CH; i++) begin
            w[i*EN_STRIDE] = e[i];
        end
        enables_word = w;
    endfunction

    // =========================================================
    // channel engines and their configuration
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        if (i == UNMATCHED_CH) begin : g_last
            assign eff_en[i] = q.en[i];
        end else begin : g_slot
            assign eff_en[i] = q.en[i] & PID_SLOT_FILTER_ENABLE[i];
        end
        assign ch_if[i].en    = eff_en[i];
        assign ch_if[i].wr    = do_write && cur_ch == 3'(i);
        assign ch_if[i].start = q.start[i];
        assign ch_if[i].stop  = q.stop[i];
        assign ch_if[i].rp    = q.rp[i];
        assign ch_if[i].sub   = q.sub[i];
        assign stalled[i]     = ch_if[i].stalled;
        assign warn_ev[i]     = ch_if[i].warn_ev;
        assign stall_ev[i]    = ch_if[i].stall_ev;
        assign wp[i]          = ch_if[i].wp;

        twr_chan u_chan (
            .clk   (CLK),
            .rst_n (RST_N),
            .ce    (CE),
            .ch    (ch_if[i])
        );
    end

    twr_route u_route (
        .hit       (PKT_MATCH_HIT),
        .slot      (PKT_MATCH_SLOT),
        .filter_en (PID_SLOT_FILTER_ENABLE),
        .eff_en    (eff_en),
        .bypass    (q.bypass),
        .chan      (head_ch),
        .ok        (head_ok)
    );

    // =========================================================
    // stream side: channel held for the body of a packet
    assign accept   = PKT_VALID && q.pkt_ready;
    assign cur_ch   = PKT_SOP ? head_ch : q.pkt_ch;
    assign cur_ok   = (PKT_SOP ? head_ok : q.pkt_ok) && eff_en[cur_ch];
    // a stalled channel drops its words so other channels keep flowing
    assign do_write = accept && cur_ok && !stalled[cur_ch];
    assign apb_done = PSEL && PENABLE && q.pready;

    // =========================================================
    // next state
    always_comb begin
        d = q;
        // memory write slot: one word in flight, ready only when empty
        if (q.mem_valid && MEM_WR_READY) begin
            d.mem_valid = 1'b0;
        end
        if (accept && PKT_SOP) begin
            d.pkt_ch = head_ch;
            d.pkt_ok = head_ok;
        end
        if (do_write) begin
            d.mem_valid = 1'b1;
            d.mem_addr  = wp[cur_ch];
            d.mem_data  = PKT_DATA;
        end
        d.pkt_ready = !d.mem_valid;

        // interrupt status: hardware set wins over a write-one clear
        if (apb_done && PWRITE && PADDR == OFF_INT_STS) begin
            d.sts = q.sts & ~PWDATA[15:0];
        end
        d.sts = d.sts | {stall_ev, warn_ev};

        // register writes take effect on the completing edge
        if (apb_done && PWRITE) begin
            if (PADDR == OFF_ENABLES) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    d.en[i] = PWDATA[i*EN_STRIDE];
                end
            end else if (PADDR == OFF_MODE) begin
                d.bypass = PWDATA[MODE_BYPASS];
            end else if (PADDR == OFF_INT_MASK) begin
                d.mask = PWDATA[15:0];
            end else if (bank_hit(PADDR, OFF_START)) begin
                d.start[PADDR[4:2]] = PWDATA[31:ALIGN_BITS];
            end else if (bank_hit(PADDR, OFF_END)) begin
                d.stop[PADDR[4:2]] = PWDATA[31:ALIGN_BITS];
            end else if (bank_hit(PADDR, OFF_RDPTR)) begin
                d.rp[PADDR[4:2]] = PWDATA[31:ALIGN_BITS];
            end else if (bank_hit(PADDR, OFF_SUB)) begin
                d.sub[PADDR[4:2]] = PWDATA[31:ALIGN_BITS];
            end
        end
        d.irq = |(d.sts & d.mask);

        // one wait state; read data and error load on the same edge that raises ready
        d.pready = PSEL && PENABLE && !q.pready;
        d.slverr = 1'b0;
        d.prdata = RST_WORD;
        if (PSEL && PENABLE && !q.pready) begin
            if (PADDR == OFF_ENABLES) begin
                d.prdata = enables_word(q.en);
            end else if (PADDR == OFF_MODE) begin
                d.prdata = {31'h0000_0000, q.bypass};
            end else if (PADDR == OFF_INT_STS) begin
                d.prdata = {16'h0000, q.sts};
            end else if (PADDR == OFF_INT_MASK) begin
                d.prdata = {16'h0000, q.mask};
            end else if (bank_hit(PADDR, OFF_START)) begin
                d.prdata = {q.start[PADDR[4:2]], 3'h0};
            end else if (bank_hit(PADDR, OFF_END)) begin
                d.prdata = {q.stop[PADDR[4:2]], 3'h0};
            end else if (bank_hit(PADDR, OFF_RDPTR)) begin
                d.prdata = {q.rp[PADDR[4:2]], 3'h0};
            end else if (bank_hit(PADDR, OFF_SUB)) begin
                d.prdata = {q.sub[PADDR[4:2]], 3'h0};
            end else if (bank_hit(PADDR, OFF_WRPTR)) begin
                d.prdata = {wp[PADDR[4:2]], 3'h0};
            end else begin
                d.slverr = 1'b1;
            end
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else if (CE) begin
            q <= d;
        end
    end

    // =========================================================
    // outputs
    assign PRDATA       = q.prdata;
    assign PREADY       = q.pready;
    assign PSLVERR      = q.slverr;
    assign PKT_READY    = q.pkt_ready;
    assign MEM_WR_VALID = q.mem_valid;
    assign MEM_WR_ADDR  = {q.mem_addr, 3'h0};
    assign MEM_WR_DATA  = q.mem_data;
    assign IRQ          = q.irq;

    // =========================================================
    // checks
    gated_slot_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && cur_ch != 3'(UNMATCHED_CH)) |-> PID_SLOT_FILTER_ENABLE[cur_ch])
        else $error("write to slot channel with filter off");
    unmatched_to_last_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (accept && PKT_SOP && !PKT_MATCH_HIT) |-> head_ch == 3'(UNMATCHED_CH))
        else $error("unmatched packet not routed to last channel");
    bypass_to_last_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (PKT_SOP && q.bypass) |-> head_ch == 3'(UNMATCHED_CH))
        else $error("bypass packet not routed to last channel");
    start_low_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (PREADY && (PADDR[11:5] == OFF_START[11:5] || PADDR[11:5] == OFF_END[11:5]))
        |-> PRDATA[2:0] == 3'h0)
        else $error("alignment bits read nonzero");
    ctrl_reserved_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (PREADY && PADDR == OFF_ENABLES) |-> (PRDATA & 32'hEEEE_EEEE) == 32'h0000_0000)
        else $error("reserved enable bits read nonzero");
    warn_sets_irq_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && (|(warn_ev & q.mask[7:0]))) |=> IRQ && (|(q.sts[7:0] & $past(warn_ev))))
        else $error("warning did not raise status and interrupt");
    apb_wait_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("apb answer not after one wait state");
    mem_from_wp_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && do_write) |=> MEM_WR_VALID && MEM_WR_ADDR[31:3] == $past(wp[cur_ch]))
        else $error("memory address not current write pointer");
endmodule

// [verif/ts_write_ring_buffer_channels_tb.sv]
`timescale 1ns/100ps
module ts_write_ring_buffer_channels_tb;
    import twr_pkg::*;
    logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, slow;
    logic        pkt_valid, pkt_sop, pkt_ready, hit, mem_valid, mem_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr;
    logic [63:0] pkt_data, mem_data;
    logic [2:0]  slot;
    logic [6:0]  filt;
    logic [95:0] wr_q[$];
    logic [32:0] rd_q[$];
    int          n_errors = 0;
    int          n_compared = 0;
    int          n;

    twr_top DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PKT_VALID(pkt_valid), .PKT_SOP(pkt_sop), .PKT_DATA(pkt_data),
        .PKT_MATCH_HIT(hit), .PKT_MATCH_SLOT(slot), .PID_SLOT_FILTER_ENABLE(filt),
        .PKT_READY(pkt_ready), .MEM_WR_VALID(mem_valid), .MEM_WR_ADDR(mem_addr),
        .MEM_WR_DATA(mem_data), .MEM_WR_READY(mem_ready), .IRQ(irq));
    twr_mem_model MEM (.clk(clk), .rst_n(rst_n), .slow(slow), .ready(mem_ready));

    // =========================================================
    // clock and hang guard
    initial begin
        clk = 1'h0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        fail("run did not finish");
        stop_test();
    end

    // =========================================================
    // reporting
    task automatic fail(input string msg);
        n_errors++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic check(input logic [95:0] got, input logic [95:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fail($sformatf("%s got %h expected %h", msg, got, exp));
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // =========================================================
    // watcher: each completed read or memory write consumes the oldest note
    always @(posedge clk) begin
        if (mem_valid === 1'h1 && mem_ready === 1'h1) begin
            if (wr_q.size() == 0) fail("memory write nobody expected");
            else check({mem_addr, mem_data}, wr_q.pop_front(), "memory write");
        end
        if (psel && penable && !pwrite && pready === 1'h1) begin
            if (rd_q.size() == 0) fail("read nobody expected");
            else check({pslverr, prdata}, rd_q.pop_front(), "register read");
        end
    end

    // =========================================================
    // apb master: one idle cycle after each access keeps drives single per step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            fail("no apb answer");
            stop_test();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        rd_q.push_back({err, e});
        apb(1'h0, a, 32'h0);
    endtask
    function automatic logic [11:0] ra(input logic [11:0] off, input int c);
        return off + 12'(4 * c);
    endfunction
    function automatic logic [31:0] base(input int c);
        return 32'(c + 1) << 12;
    endfunction

    // =========================================================
    // stream driver: word held until taken; keep=0 means it must be dropped
    task automatic send(input logic sop, input logic h, input logic [2:0] s,
                        input logic [31:0] ea, input logic keep);
        logic [63:0] d;
        int          k;
        d = {$urandom, $urandom};
        if (keep) wr_q.push_back({ea, d});
        pkt_valid <= 1'h1;
        pkt_sop <= sop;
        hit <= h;
        slot <= s;
        pkt_data <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pkt_ready !== 1'h1 && k < 50);
        if (pkt_ready !== 1'h1) begin
            fail("stream word never taken");
            stop_test();
        end
        pkt_valid <= 1'h0;
        @(posedge clk);
    endtask
    task automatic done(input string name);
        int k;
        for (k = 0; k < 200 && (wr_q.size() + rd_q.size()) > 0; k++) @(posedge clk);
        if ((wr_q.size() + rd_q.size()) > 0) begin
            fail("expected results never appeared");
            stop_test();
        end
        $display("test %s finished", name);
    endtask

    // =========================================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, pkt_valid, pkt_sop, hit, slow} = 8'h0;
        {paddr, pwdata, pkt_data, slot} = '0;
        ce = 1'h1;
        filt = 7'h7F;
        void'($urandom(32'h4F4E3C4B));
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        // registers: reset values, reserved and read-only bits, unmapped place
        rd(OFF_ENABLES, 32'h0, 1'h0);
        rd(ra(OFF_WRPTR, 7), 32'h0, 1'h0);
        apb(1'h1, OFF_ENABLES, 32'hFFFFFFFF);
        rd(OFF_ENABLES, 32'h11111111, 1'h0);
        apb(1'h1, OFF_ENABLES, 32'h0);
        apb(1'h1, OFF_WRPTR, 32'hFFFFFFFF);
        rd(OFF_WRPTR, 32'h0, 1'h0);
        rd(12'h100, 32'h0, 1'h1);
        for (n = 0; n < NUM_CH; n++) begin
            rd(ra(OFF_START, n), 32'h0, 1'h0);
            apb(1'h1, ra(OFF_START, n), 32'hFFFFFFFF);
            rd(ra(OFF_START, n), 32'hFFFFFFF8, 1'h0);
            apb(1'h1, ra(OFF_END, n), 32'hFFFFFFFF);
            rd(ra(OFF_END, n), 32'hFFFFFFF8, 1'h0);
            apb(1'h1, ra(OFF_START, n), base(n));
            apb(1'h1, ra(OFF_END, n), base(n) + 32'hF8);
        end
        done("registers");
        // routing by slot, filter gate, unmatched and bypass, memory stalling
        slow <= 1'h1;
        apb(1'h1, OFF_ENABLES, 32'h11111111);
        for (n = 0; n < 7; n++) begin
            send(1'h1, 1'h1, 3'(n), base(n), 1'h1);
            send(1'h0, 1'h0, 3'h0, base(n) + 32'h8, 1'h1);
        end
        filt[3] <= 1'h0;
        @(posedge clk);
        // a slot whose filter is off counts as unmatched, so its head lands in the last channel
        send(1'h1, 1'h1, 3'h3, base(7), 1'h1);
        filt[3] <= 1'h1;
        send(1'h1, 1'h0, 3'h0, base(7) + 32'h8, 1'h1);
        apb(1'h1, OFF_ENABLES, 32'h11111110);
        send(1'h1, 1'h1, 3'h0, 32'h0, 1'h0);
        apb(1'h1, OFF_MODE, 32'h1);
        send(1'h1, 1'h1, 3'h2, base(7) + 32'h10, 1'h1);
        apb(1'h1, OFF_MODE, 32'h0);
        done("routing");
        // wrap after the inclusive end word, channel idle while reprogrammed
        slow <= 1'h0;
        apb(1'h1, OFF_ENABLES, 32'h0);
        apb(1'h1, ra(OFF_START, 7), 32'h3000);
        apb(1'h1, ra(OFF_END, 7), 32'h3008);
        apb(1'h1, OFF_ENABLES, 32'h10000000);
        send(1'h1, 1'h0, 3'h0, 32'h3000, 1'h1);
        send(1'h0, 1'h0, 3'h0, 32'h3008, 1'h1);
        send(1'h0, 1'h0, 3'h0, 32'h3000, 1'h1);
        done("wrap");
        // stall at the consumer pointer, early warning, interrupt, reactivation
        apb(1'h1, OFF_ENABLES, 32'h0);
        apb(1'h1, ra(OFF_START, 7), 32'h4000);
        apb(1'h1, ra(OFF_END, 7), 32'h40F8);
        apb(1'h1, ra(OFF_RDPTR, 7), 32'h4010);
        apb(1'h1, ra(OFF_SUB, 7), 32'h8);
        apb(1'h1, OFF_INT_MASK, 32'h80);
        apb(1'h1, OFF_ENABLES, 32'h10000000);
        send(1'h1, 1'h0, 3'h0, 32'h4000, 1'h1);
        send(1'h0, 1'h0, 3'h0, 32'h4008, 1'h1);
        send(1'h0, 1'h0, 3'h0, 32'h0, 1'h0);
        rd(ra(OFF_WRPTR, 7), 32'h4010, 1'h0);
        rd(OFF_INT_STS, 32'h8080, 1'h0);
        check(96'(irq), 96'h1, "interrupt raised");
        apb(1'h1, OFF_INT_STS, 32'h8080);
        rd(OFF_INT_STS, 32'h0, 1'h0);
        check(96'(irq), 96'h0, "interrupt cleared");
        apb(1'h1, OFF_ENABLES, 32'h0);
        apb(1'h1, OFF_ENABLES, 32'h10000000);
        send(1'h1, 1'h0, 3'h0, 32'h4000, 1'h1);
        done("stall");
        // clock enable low: a word offered now must leave pointer, status and memory alone
        ce <= 1'h0;
        send(1'h1, 1'h0, 3'h0, 32'h0, 1'h0);
        ce <= 1'h1;
        rd(ra(OFF_WRPTR, 7), 32'h4008, 1'h0);
        rd(OFF_INT_STS, 32'h0080, 1'h0);
        done("freeze");
        stop_test();
    end
endmodule

// [verif/twr_mem_model.sv]
`timescale 1ns/100ps
// =========================================================
// external memory stand-in on the write side of the channels
module twr_mem_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      ready
);
    // slow mode stalls at random so that held write requests get exercised
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'h0;
        end else begin
            ready <= slow ? ($urandom_range(3) == 0) : 1'h1;
        end
    end
endmodule
